// file: rtl/fspam_pkg.sv
// fspam_pkg: constants for the flash self-programming address mapper
// assumes a 4k-word flash with 32-word pages and a 16-bit pointer
package fspam_pkg;
  // ----------------------------------------------------------------------
  // register map (word aligned byte offsets)
  // ----------------------------------------------------------------------
  localparam logic [3:0] FSPAM_OFF_CTRL = 4'h0;
  localparam logic [3:0] FSPAM_OFF_PTR = 4'h4;
  localparam logic [3:0] FSPAM_OFF_CFG = 4'h8;
  localparam logic [3:0] FSPAM_OFF_MAP = 4'hc;
  // ----------------------------------------------------------------------
  // control/status fields
  // ----------------------------------------------------------------------
  localparam int FSPAM_BIT_EN = 0;
  localparam int FSPAM_BIT_ERS = 1;
  localparam int FSPAM_BIT_WRT = 2;
  localparam int FSPAM_BIT_REEN = 4;
  localparam int FSPAM_BIT_BUSY = 6;
  localparam int FSPAM_BIT_EEBUSY = 7;
  localparam logic [7:0] FSPAM_CTRL_RST = 8'h00;
  localparam logic [1:0] FSPAM_BOOTSZ_RST = 2'h0;
  // ----------------------------------------------------------------------
  // address geometry
  // ----------------------------------------------------------------------
  localparam int FSPAM_COUNTER_TOP_BIT = 11;
  localparam int FSPAM_IN_PAGE_TOP_BIT = 4;
  localparam int FSPAM_POINTER_COUNTER_TOP_BIT = 12;
  localparam int FSPAM_POINTER_IN_PAGE_TOP_BIT = 5;
  localparam logic [11:0] FSPAM_RWW_LAST = 12'hbff;
  localparam logic [11:0] FSPAM_BOOT_11 = 12'hf80;
  localparam logic [11:0] FSPAM_BOOT_10 = 12'hf00;
  localparam logic [11:0] FSPAM_BOOT_01 = 12'he00;
  localparam logic [11:0] FSPAM_BOOT_00 = 12'hc00;
  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam logic [2:0] FSPAM_ARM_WINDOW = 3'h4;
  localparam int FSPAM_CLK_MHZ = 100;
  localparam int FSPAM_PROG_US = 3700;
  localparam int FSPAM_PROG_CYC = FSPAM_PROG_US * FSPAM_CLK_MHZ;
  typedef enum logic [1:0] {
    FSPAM_IDLE = 2'b00,
    FSPAM_ARMED = 2'b01,
    FSPAM_PROG = 2'b10
  } fspam_state_e;
endpackage

// file: rtl/fspam_top.sv
// fspam_top: self-programming sequencer and address mapper for program flash
// assumes an avalon-mm master on mclk_i and a cpu that strobes store/load
// How it works
// [RULE1] boot size code puts the boot region at F80/F00/E00/C00.
// [RULE2] read-while-write region is 000-BFF, blocking region C00-FFF.
// [RULE3] word address is 12 bits; low 5 pick word, upper 7 page.
// [RULE4] erase and write take page number from pointer bits 12..6.
// [RULE5] pointer bits 5..1 pick buffer word; software zeroes them on write.
// [RULE6] pointer bits 15..13 are ignored everywhere.
// [RULE7] pointer bit 0 zero on store; byte select on load.
// [RULE8] during erase or write only the blocking region reads.
// [RULE9] software polls the enable bit to zero before a new command.
// [RULE10] software waits for eeprom write busy clear before control write.
// [RULE11] region busy means not ready; software repeats re-enable until clear.
// [RULE12] update order: erase, re-enable, fill buffer, write from page start.
// [RULE13] software keeps interrupts off around the timed store sequence.
// [RULE14] enable bit clears itself when the commanded operation ends.
// [RULE15] store must come within four cycles of control write.
// [RULE16] region busy flag stays set while the region is busy.
// [RULE17] eeprom write blocks flash programming and fuse/lock reads.
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module fspam_top
  import fspam_pkg::*;
#(
  parameter int PROG_CYCLES = FSPAM_PROG_CYC
)
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic store_i,
  input wire logic load_i,
  input wire logic [15:0] load_ptr_i,
  input wire logic eeprom_write_busy_i,
  input wire logic fuse_read_i,
  output logic buf_we_o,
  output logic [4:0] buf_word_o,
  output logic erase_o,
  output logic write_o,
  output logic [6:0] page_o,
  output logic [11:0] rd_word_o,
  output logic rd_byte_o,
  output logic rd_ok_o,
  output logic fuse_read_ok_o
);
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [11:0] word_of(input logic [15:0] p);
    word_of = p[FSPAM_POINTER_COUNTER_TOP_BIT:1]; // [RULE3] [RULE6]
  endfunction

  function automatic logic in_rww(input logic [11:0] w);
    in_rww = (w <= FSPAM_RWW_LAST); // [RULE2]
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  fspam_state_e state_q;
  logic [7:0] ctrl_q;
  logic [15:0] ptr_q;
  logic [1:0] bootsz_q;
  logic [2:0] arm_q;
  logic [31:0] prog_cnt_q;
  logic region_busy_q;
  logic [11:0] boot_start;
  logic ctrl_wr;
  logic [11:0] rd_word;

  always_comb
  begin
    unique case (bootsz_q) // [RULE1]
      2'b11: boot_start = FSPAM_BOOT_11;
      2'b10: boot_start = FSPAM_BOOT_10;
      2'b01: boot_start = FSPAM_BOOT_01;
      2'b00: boot_start = FSPAM_BOOT_00;
    endcase
  end

  // eeprom write blocks control writes outright [RULE17]
  assign ctrl_wr = avs_write_i && !avs_waitrequest_o && avs_address_i == FSPAM_OFF_CTRL
                   && avs_byteenable_i[0] && !eeprom_write_busy_i && state_q == FSPAM_IDLE;
  assign rd_word = word_of(load_ptr_i);

  // ----------------------------------------------------------------------
  // bus slave: one wait cycle per access
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      avs_waitrequest_o <= 1'b1;
    else if ((avs_read_i || avs_write_i) && avs_waitrequest_o)
      avs_waitrequest_o <= 1'b0;
    else
      avs_waitrequest_o <= 1'b1;
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      avs_readdata_o <= 32'h0;
    else if (avs_read_i && avs_waitrequest_o)
    begin
      unique case (avs_address_i)
        FSPAM_OFF_CTRL: avs_readdata_o <= {24'h0, eeprom_write_busy_i, region_busy_q, 1'b0,
                                           ctrl_q[4:0]}; // [RULE16]
        FSPAM_OFF_PTR: avs_readdata_o <= {16'h0, ptr_q};
        FSPAM_OFF_CFG: avs_readdata_o <= {30'h0, bootsz_q};
        FSPAM_OFF_MAP: avs_readdata_o <= {20'h0, boot_start};
        default: avs_readdata_o <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ptr_q <= 16'h0;
      bootsz_q <= FSPAM_BOOTSZ_RST;
    end
    else if (avs_write_i && !avs_waitrequest_o)
    begin
      if (avs_address_i == FSPAM_OFF_PTR)
      begin
        if (avs_byteenable_i[0])
          ptr_q[7:0] <= avs_writedata_i[7:0];
        if (avs_byteenable_i[1])
          ptr_q[15:8] <= avs_writedata_i[15:8];
      end
      if (avs_address_i == FSPAM_OFF_CFG && avs_byteenable_i[0])
        bootsz_q <= avs_writedata_i[1:0];
    end
  end

  // ----------------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_q <= FSPAM_IDLE;
      ctrl_q <= FSPAM_CTRL_RST;
      arm_q <= 3'h0;
      prog_cnt_q <= 32'h0;
      erase_o <= 1'b0;
      write_o <= 1'b0;
      buf_we_o <= 1'b0;
      buf_word_o <= 5'h0;
      page_o <= 7'h0;
    end
    else
    begin
      erase_o <= 1'b0;
      write_o <= 1'b0;
      buf_we_o <= 1'b0;
      unique case (state_q)
        FSPAM_IDLE:
        begin
          if (ctrl_wr && avs_writedata_i[FSPAM_BIT_EN])
          begin
            ctrl_q <= {3'h0, avs_writedata_i[4:0]};
            arm_q <= FSPAM_ARM_WINDOW;
            state_q <= FSPAM_ARMED;
          end
        end
        FSPAM_ARMED:
        begin
          if (store_i && !eeprom_write_busy_i)
          begin
            page_o <= ptr_q[FSPAM_POINTER_COUNTER_TOP_BIT:FSPAM_POINTER_IN_PAGE_TOP_BIT + 1]; // [RULE4]
            if (ctrl_q[FSPAM_BIT_ERS] || ctrl_q[FSPAM_BIT_WRT])
            begin
              erase_o <= ctrl_q[FSPAM_BIT_ERS];
              write_o <= ctrl_q[FSPAM_BIT_WRT];
              prog_cnt_q <= PROG_CYCLES;
              state_q <= FSPAM_PROG;
            end
            else
            begin
              // fill and re-enable finish in one cycle [RULE14]
              if (!ctrl_q[FSPAM_BIT_REEN])
              begin
                buf_we_o <= 1'b1;
                buf_word_o <= ptr_q[FSPAM_POINTER_IN_PAGE_TOP_BIT:1]; // [RULE5]
              end
              ctrl_q <= FSPAM_CTRL_RST;
              state_q <= FSPAM_IDLE;
            end
          end
          else if (arm_q == 3'h1)
          begin
            // store missed its window: command dropped [RULE15]
            ctrl_q <= FSPAM_CTRL_RST;
            state_q <= FSPAM_IDLE;
          end
          else
            arm_q <= arm_q - 3'h1;
        end
        FSPAM_PROG:
        begin
          if (prog_cnt_q <= 32'h1)
          begin
            ctrl_q <= FSPAM_CTRL_RST; // [RULE14]
            state_q <= FSPAM_IDLE;
          end
          else
            prog_cnt_q <= prog_cnt_q - 32'h1;
        end
        default: state_q <= FSPAM_IDLE;
      endcase
    end
  end

  // region busy: set by erase/write, cleared only by a re-enable after it ends
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      region_busy_q <= 1'b0;
    else if (state_q == FSPAM_ARMED && store_i && !eeprom_write_busy_i
             && (ctrl_q[FSPAM_BIT_ERS] || ctrl_q[FSPAM_BIT_WRT]))
      region_busy_q <= 1'b1; // [RULE16]
    else if (state_q == FSPAM_ARMED && store_i && !eeprom_write_busy_i && ctrl_q[FSPAM_BIT_REEN])
      region_busy_q <= 1'b0; // [RULE11]
  end

  // ----------------------------------------------------------------------
  // load path
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rd_word_o <= 12'h0;
      rd_byte_o <= 1'b0;
      rd_ok_o <= 1'b0;
      fuse_read_ok_o <= 1'b0;
    end
    else
    begin
      rd_word_o <= rd_word;
      rd_byte_o <= load_ptr_i[0]; // [RULE7]
      // rww region unreadable while busy [RULE8] [RULE11]
      rd_ok_o <= load_i && !(in_rww(rd_word) && region_busy_q);
      fuse_read_ok_o <= fuse_read_i && !eeprom_write_busy_i; // [RULE17]
    end
  end
endmodule
`default_nettype wire

// file: testbench/fspam_top_assertions.sv
// fspam_top_assertions: port checks for the flash self-programming mapper
// assumes pointer writes always enable both low byte lanes
`timescale 1ns/10ps
`default_nettype none
module fspam_top_assertions
  import fspam_pkg::*;
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic avs_waitrequest_o,
  input wire logic load_i,
  input wire logic [15:0] load_ptr_i,
  input wire logic eeprom_write_busy_i,
  input wire logic fuse_read_i,
  input wire logic buf_we_o,
  input wire logic [4:0] buf_word_o,
  input wire logic erase_o,
  input wire logic write_o,
  input wire logic [6:0] page_o,
  input wire logic [11:0] rd_word_o,
  input wire logic rd_byte_o,
  input wire logic rd_ok_o,
  input wire logic fuse_read_ok_o
);
  logic [15:0] ptr_q;
  logic [15:0] ld_q;
  // pointer copy taken at the bus completion edge, as the slave does
  always_ff @(posedge mclk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      ptr_q <= 16'h0000;
      ld_q <= 16'h0000;
    end
    else
    begin
      ld_q <= load_ptr_i;
      if (avs_write_i && !avs_waitrequest_o && avs_address_i == FSPAM_OFF_PTR)
        ptr_q <= avs_writedata_i[15:0];
    end
  default clocking dc @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  a_word_map: assert property (load_i |=> rd_word_o == ld_q[12:1]) else $error("word map");
  a_byte_sel: assert property (load_i |=> rd_byte_o == ld_q[0]) else $error("byte select");
  a_boot_read: assert property (load_i && load_ptr_i[12:1] > FSPAM_RWW_LAST |=> rd_ok_o) else $error("blocking_boot_region");
  a_rww_block: assert property ((erase_o || write_o) ##[1:6] (load_i && load_ptr_i[12:1] <= FSPAM_RWW_LAST)
    |=> !rd_ok_o) else $error("rww read");
  a_page_sel: assert property (erase_o || write_o |-> page_o == ptr_q[12:6]) else $error("page");
  a_buf_word: assert property (buf_we_o |-> buf_word_o == ptr_q[5:1]) else $error("buffer word");
  a_fuse_gate: assert property (fuse_read_i |=> fuse_read_ok_o == !$past(eeprom_write_busy_i)) else $error("fuse");
  a_one_shot: assert property (erase_o |=> !erase_o && !write_o) else $error("erase twice");
  c_erase: cover property (erase_o);
  c_write: cover property (write_o);
  c_fill: cover property (buf_we_o);
endmodule
bind fspam_top fspam_top_assertions u_fspam_top_assertions (.*);
`default_nettype wire

// file: testbench/fspam_sw.sv
// fspam_sw: boot-loader side, an avalon-mm master plus the store strobe
// assumes callers enter its tasks just after a rising edge of mclk_i
`timescale 1ns/10ps
`default_nettype none
module fspam_sw
  import fspam_pkg::*;
(
  input wire logic mclk_i,
  input wire logic avs_waitrequest_i,
  input wire logic [31:0] avs_readdata_i,
  output logic [3:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [31:0] avs_writedata_o,
  output logic store_o,
  output logic tmo_o
);
  initial {avs_address_o, avs_read_o, avs_write_o, avs_writedata_o, store_o, tmo_o} = '0;
  // returns one edge after release so strobes never toggle twice in a step
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address_o <= a;
    avs_writedata_o <= d;
    avs_write_o <= w;
    avs_read_o <= !w;
    @(posedge mclk_i);
    while (avs_waitrequest_i && n < 50)
    begin
      n++;
      @(posedge mclk_i);
    end
    q = avs_readdata_i;
    tmo_o <= tmo_o | (n == 50);
    avs_write_o <= 1'b0;
    avs_read_o <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic st();
    store_o <= 1'b1;
    @(posedge mclk_i);
    store_o <= 1'b0;
  endtask
  // nothing else can run between control write and store: interrupts stay off
  task automatic spm(input logic [7:0] v, input logic [15:0] z);
    logic [31:0] q;
    int n;
    q = 32'h0000_0081;
    n = 0;
    while ((q[FSPAM_BIT_EN] || q[FSPAM_BIT_EEBUSY]) && n < 100)
    begin
      bus(1'b0, FSPAM_OFF_CTRL, 32'h0, q);
      n++;
    end
    tmo_o <= tmo_o | (n == 100);
    bus(1'b1, FSPAM_OFF_PTR, {16'h0000, z}, q);
    bus(1'b1, FSPAM_OFF_CTRL, {24'h0, v}, q);
    st();
  endtask
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// testbench: mapper driven by the boot-loader model, checked against a local model
// assumes fspam_top with a shortened programming time
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module testbench
  import fspam_pkg::*;
;
  logic mclk_i, nrst_i, avs_read_i, avs_write_i, store_i, load_i, eeprom_write_busy_i, fuse_read_i, tmo;
  logic avs_waitrequest_o, buf_we_o, erase_o, write_o, rd_byte_o, rd_ok_o, fuse_read_ok_o;
  logic [3:0] avs_address_i, avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic [15:0] load_ptr_i, r;
  logic [4:0] buf_word_o;
  logic [6:0] page_o;
  logic [11:0] rd_word_o;
  logic [6:0] pgq[$];
  logic [4:0] wdq[$];
  int fails, cmp_count, pe[$];
  fspam_top #(.PROG_CYCLES(20)) u_fspam_top (.*);
  fspam_sw u_fspam_sw (.mclk_i(mclk_i), .avs_waitrequest_i(avs_waitrequest_o), .avs_readdata_i(avs_readdata_o),
    .avs_address_o(avs_address_i), .avs_read_o(avs_read_i), .avs_write_o(avs_write_i),
    .avs_writedata_o(avs_writedata_i), .store_o(store_i), .tmo_o(tmo));
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i)
  begin
    if (erase_o || write_o)
      pgq.push_back(page_o);
    if (buf_we_o)
      wdq.push_back(buf_word_o);
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic rd(input logic [3:0] a);
    u_fspam_sw.bus(1'b0, a, 32'h0, q);
  endtask
  task automatic ld(input logic [15:0] p, input logic b);
    int w;
    w = p[12:1];
    load_ptr_i <= p;
    load_i <= 1'b1;
    @(posedge mclk_i);
    load_i <= 1'b0;
    #1;
    `CHK(rd_word_o, 12'(w))
    `CHK(rd_byte_o, p[0])
    `CHK(rd_ok_o, (w > FSPAM_RWW_LAST) || !b)
    @(posedge mclk_i);
  endtask
  task automatic fz(input logic e);
    eeprom_write_busy_i <= e;
    fuse_read_i <= 1'b1;
    @(posedge mclk_i);
    fuse_read_i <= 1'b0;
    #1;
    `CHK(fuse_read_ok_o, !e)
    @(posedge mclk_i);
  endtask
  task automatic wt();
    q = 32'h1;
    for (int i = 0; i < 60 && q[FSPAM_BIT_EN]; i++)
      rd(FSPAM_OFF_CTRL);
    `CHK(q[FSPAM_BIT_EN], 1'b0)
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    {nrst_i, load_i, load_ptr_i, eeprom_write_busy_i, fuse_read_i} = '0;
    avs_byteenable_i = 4'hf;
    r = 16'h3fd8;
    repeat (20) @(posedge mclk_i);
    nrst_i <= 1'b1;
    #1 `CHK(avs_waitrequest_o, 1'b1)
    @(posedge mclk_i);
    rd(FSPAM_OFF_CTRL);
    `CHK(q[7:0], FSPAM_CTRL_RST)
    rd(FSPAM_OFF_CFG);
    `CHK(q[1:0], FSPAM_BOOTSZ_RST)
    for (int c = 0; c < 4; c++)
    begin
      u_fspam_sw.bus(1'b1, FSPAM_OFF_CFG, 32'(c), q);
      rd(FSPAM_OFF_MAP);
      `CHK(q[11:0], 12'(4096 - (128 << (3 - c))))
    end
    rd(4'h2);
    `CHK(q, 32'h0)
    repeat (8)
    begin
      r = lfsr(r);
      ld(r, 1'b0);
    end
    // lone erase, then reads while the region is busy
    r = lfsr(r);
    pe.push_back(r[12:6]);
    u_fspam_sw.spm(8'h03, {r[15:6], 6'h00});
    repeat (3) @(posedge mclk_i);
    ld(16'h0100, 1'b1);
    ld(16'h1ffe, 1'b1);
    wt();
    `CHK(q[FSPAM_BIT_EN], 1'b0)
    `CHK(q[FSPAM_BIT_BUSY], 1'b1)
    ld(16'h0100, 1'b1);
    u_fspam_sw.spm(8'h11, 16'h0000);
    wt();
    `CHK(q[FSPAM_BIT_BUSY], 1'b0)
    // full page update in the documented order
    r = lfsr(r);
    pe.push_back(r[12:6]);
    pe.push_back(r[12:6]);
    u_fspam_sw.spm(8'h03, {r[15:6], 6'h00});
    u_fspam_sw.spm(8'h11, 16'h0000);
    for (int i = 0; i < 32; i++)
      u_fspam_sw.spm(8'h01, {r[15:6], 6'h00} + 16'(2 * i));
    u_fspam_sw.spm(8'h05, {r[15:6], 6'h00});
    u_fspam_sw.spm(8'h11, 16'h0000);
    wt();
    // control write during eeprom busy must not start an erase
    fz(1'b1);
    u_fspam_sw.bus(1'b1, FSPAM_OFF_CTRL, 32'h3, q);
    u_fspam_sw.st();
    rd(FSPAM_OFF_CTRL);
    `CHK(q[7:0], 8'h80)
    fz(1'b0);
    // store too late after the control write is dropped
    u_fspam_sw.bus(1'b1, FSPAM_OFF_CTRL, 32'h5, q);
    repeat (6) @(posedge mclk_i);
    u_fspam_sw.st();
    repeat (4) @(posedge mclk_i);
    `CHK(pgq.size(), pe.size())
    foreach (pe[i])
      `CHK(pgq[i], 7'(pe[i]))
    `CHK(wdq.size(), 32)
    for (int i = 0; i < 32; i++)
      `CHK(wdq[i], 5'(i))
    `CHK(tmo, 1'b0)
    end_of_test();
  end
  initial
  begin
    repeat (100000) @(posedge mclk_i);
    fails++;
    end_of_test();
  end
endmodule
`default_nettype wire
